// file: pkg/insn_decode_pkg.sv
/*
  constants, types and encodings for the instruction decode and timing block.
  assumes one core clock; the surrounding core supplies words and file data.
*/
// Overview of operation
// - each instruction is one 14-bit word: opcode plus operands, four categories
// - byte ops: destination bit zero writes W, one writes the file register
// - file address is a 7-bit field, 0x00 to 0x7F in current bank
// - bit ops: bit-select picks one bit of the addressed 8-bit register
// - literal ops take an eight- or eleven-bit constant per instruction
// - one instruction cycle is four consecutive oscillator periods
// - one cycle each; PC change or true test adds a no-op cycle
// - file operands are read, modified, then stored, even for pure writes
// - don't-care opcode bits are ignored by the decoder
// - byte ops encode 00, four-bit op, destination bit, 7-bit address
// - self-modified I/O registers use pin levels, not output latches
// - writing timer-zero count clears prescaler when assigned to timer zero; the code clears it on every such write, with no assignment check
package insn_decode_pkg;
  localparam int WORD_W = 14;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int BIT_POS_LSB = 7;
  localparam int BYTE_OP_LSB = 8;
  localparam int CAT_LSB = 12;
  localparam int DEST_POS = 7;
  localparam int PHASES = 4;
  localparam logic [1:0] CAT_BYTE = 2'h0;
  localparam logic [1:0] CAT_BIT = 2'h1;
  localparam logic [1:0] CAT_JUMP = 2'h2;
  localparam logic [1:0] CAT_LIT = 2'h3;
  localparam logic [ADDR_W-1:0] TIMER_ZERO_COUNT_ADDR = 7'h01;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [DATA_W-1:0] data_t;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [PC_W-1:0] pc_t;
  typedef enum logic [1:0] {PH_Q1 = 2'b00, PH_Q2 = 2'b01, PH_Q3 = 2'b11, PH_Q4 = 2'b10} phase_t;
endpackage

// file: src/insn_alu.sv
/*
  combinational operation unit for byte, bit and literal instructions.
  assumes operands are settled during the cycle the result is taken.
*/
`timescale 1ns/1ps
module insn_alu
  import insn_decode_pkg::*;
(
  input wire insn_decode_pkg::word_t word,
  input wire insn_decode_pkg::data_t w_val,
  input wire insn_decode_pkg::data_t f_val,
  input wire logic carry_in,
  output insn_decode_pkg::data_t result,
  output logic carry_out,
  output logic carry_we,
  output logic zero_we,
  output logic skip
);
  logic [DATA_W:0] sum;
  logic [2:0] bsel;
  always_comb begin
    sum = '0;
    result = f_val;
    carry_out = carry_in;
    carry_we = 1'b0;
    zero_we = 1'b0;
    skip = 1'b0;
    bsel = word[BIT_POS_LSB +: 3];
    unique case (word[CAT_LSB +: 2])
      CAT_BYTE: begin
        unique case (word[BYTE_OP_LSB +: 4])
          4'h0: result = w_val;
          4'h1: begin
            result = 8'h00;
            zero_we = 1'b1;
          end
          4'h2: begin
            sum = {1'b0, f_val} + {1'b0, ~w_val} + 9'h001;
            result = sum[7:0];
            carry_out = sum[8];
            carry_we = 1'b1;
            zero_we = 1'b1;
          end
          4'h3: begin
            result = f_val - 8'h01;
            zero_we = 1'b1;
          end
          4'h4: begin
            result = w_val | f_val;
            zero_we = 1'b1;
          end
          4'h5: begin
            result = w_val & f_val;
            zero_we = 1'b1;
          end
          4'h6: begin
            result = w_val ^ f_val;
            zero_we = 1'b1;
          end
          4'h7: begin
            sum = {1'b0, f_val} + {1'b0, w_val};
            result = sum[7:0];
            carry_out = sum[8];
            carry_we = 1'b1;
            zero_we = 1'b1;
          end
          4'h8: begin
            result = f_val;
            zero_we = 1'b1;
          end
          4'h9: begin
            result = ~f_val;
            zero_we = 1'b1;
          end
          4'hA: begin
            result = f_val + 8'h01;
            zero_we = 1'b1;
          end
          4'hB: begin
            result = f_val - 8'h01;
            skip = (result == 8'h00);
          end
          4'hC: begin
            result = {carry_in, f_val[7:1]};
            carry_out = f_val[0];
            carry_we = 1'b1;
          end
          4'hD: begin
            result = {f_val[6:0], carry_in};
            carry_out = f_val[7];
            carry_we = 1'b1;
          end
          4'hE: result = {f_val[3:0], f_val[7:4]};
          4'hF: begin
            result = f_val + 8'h01;
            skip = (result == 8'h00);
          end
        endcase
      end
      CAT_BIT: begin
        unique case (word[11:10])
          2'h0: result[bsel] = 1'b0;
          2'h1: result[bsel] = 1'b1;
          2'h2: skip = ~f_val[bsel];
          2'h3: skip = f_val[bsel];
        endcase
      end
      CAT_JUMP: result = w_val;
      CAT_LIT: begin
        unique casez (word[11:8])
          4'b00??: result = word[LIT8_W-1:0];
          4'b01??: result = word[LIT8_W-1:0];
          4'b1000: begin
            result = w_val | word[7:0];
            zero_we = 1'b1;
          end
          4'b1001: begin
            result = w_val & word[7:0];
            zero_we = 1'b1;
          end
          4'b1010: begin
            result = w_val ^ word[7:0];
            zero_we = 1'b1;
          end
          4'b110?: begin
            sum = {1'b0, word[7:0]} + {1'b0, ~w_val} + 9'h001;
            result = sum[7:0];
            carry_out = sum[8];
            carry_we = 1'b1;
            zero_we = 1'b1;
          end
          4'b111?: begin
            sum = {1'b0, word[7:0]} + {1'b0, w_val};
            result = sum[7:0];
            carry_out = sum[8];
            carry_we = 1'b1;
            zero_we = 1'b1;
          end
          default: result = w_val;
        endcase
      end
    endcase
  end
endmodule // insn_alu

// file: src/insn_decode.sv
/*
  instruction decode and execution timing: fetch, four-phase cycle, read-modify-write.
  assumes program memory answers prog_addr with prog_word by Q3 of the same instruction cycle,
  and file memory answers file_addr with file_rdata combinationally or by Q3.
*/
`timescale 1ns/1ps
module insn_decode
  import insn_decode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire insn_decode_pkg::word_t prog_word,
  input wire insn_decode_pkg::data_t file_rdata,
  input wire logic stack_empty_n,
  input wire insn_decode_pkg::pc_t stack_top,
  output insn_decode_pkg::pc_t prog_addr,
  output insn_decode_pkg::addr_t file_addr,
  output logic file_rd,
  output logic file_we,
  output insn_decode_pkg::data_t file_wdata,
  output insn_decode_pkg::data_t w_reg,
  output logic carry_flag,
  output logic zero_flag,
  output logic prescaler_clr,
  output logic stack_push,
  output logic stack_pop,
  output logic cycle_end,
  output logic flush
);
  import insn_decode_pkg::*;

  phase_t phase_q, phase_d;
  word_t ir_q, ir_d;
  word_t fetch_q, fetch_d;
  pc_t pc_q, pc_d;
  data_t w_q, w_d;
  logic c_q, c_d, z_q, z_d;
  logic flush_q, flush_d;
  addr_t fa_q, fa_d;
  logic rd_q, rd_d, we_q, we_d, ps_q, ps_d, push_q, push_d, pop_q, pop_d, end_q, end_d;
  data_t wd_q, wd_d;
  data_t res;
  logic c_out, c_we, z_we, skip_now;
  logic skip_q, skip_d;
  pc_t jump_target;
  logic file_op, dest_f, writes_f, jump, ret_op, call_op, timer_zero_count_psa;

  insn_alu u_alu (
    .word(ir_q),
    .w_val(w_q),
    .f_val(file_rdata),
    .carry_in(c_q),
    .result(res),
    .carry_out(c_out),
    .carry_we(c_we),
    .zero_we(z_we),
    .skip(skip_now)
  );

  always_comb begin
    file_op = (ir_q[CAT_LSB +: 2] == CAT_BYTE && ir_q[11:8] != 4'h0)
      || (ir_q[CAT_LSB +: 2] == CAT_BYTE && ir_q[DEST_POS])
      || (ir_q[CAT_LSB +: 2] == CAT_BIT);
    if (ir_q[CAT_LSB +: 2] == CAT_BIT) begin
      dest_f = ~ir_q[11];
    end else begin
      dest_f = ir_q[DEST_POS];
    end
    writes_f = file_op && dest_f && !(ir_q[CAT_LSB +: 2] == CAT_BYTE && ir_q[11:8] == 4'h1
      && !ir_q[DEST_POS]);
    call_op = (ir_q[CAT_LSB +: 2] == CAT_JUMP) && !ir_q[11];
    jump = (ir_q[CAT_LSB +: 2] == CAT_JUMP);
    ret_op = (ir_q[13:4] == 10'h000 && ir_q[3:1] == 3'h4)
      || (ir_q[CAT_LSB +: 2] == CAT_LIT && ir_q[11:10] == 2'h1);
    timer_zero_count_psa = writes_f && (ir_q[ADDR_W-1:0] == TIMER_ZERO_COUNT_ADDR);
    jump_target = {pc_q[12:11], ir_q[LIT11_W-1:0]};
  end

  always_comb begin
    phase_d = phase_q;
    ir_d = ir_q;
    fetch_d = fetch_q;
    pc_d = pc_q;
    w_d = w_q;
    c_d = c_q;
    z_d = z_q;
    flush_d = flush_q;
    skip_d = skip_q;
    fa_d = ir_q[ADDR_W-1:0];
    rd_d = 1'b0;
    we_d = 1'b0;
    wd_d = wd_q;
    ps_d = 1'b0;
    push_d = 1'b0;
    pop_d = 1'b0;
    end_d = 1'b0;
    unique case (phase_q)
      PH_Q1: phase_d = PH_Q2;
      PH_Q2: begin
        phase_d = PH_Q3;
        rd_d = file_op && !flush_q;
      end
      PH_Q3: begin
        phase_d = PH_Q4;
        fetch_d = prog_word;
        if (!flush_q) begin
          wd_d = res;
          skip_d = skip_now;
          if (writes_f) begin
            we_d = 1'b1;
            ps_d = timer_zero_count_psa;
          end else if (!jump && !(ir_q[CAT_LSB +: 2] == CAT_BIT)) begin
            w_d = res;
          end
          if (c_we) begin
            c_d = c_out;
          end
          if (z_we) begin
            z_d = (res == 8'h00);
          end
          if (ir_q[13:4] == 10'h000 && ir_q[3:0] == 4'h0 && !ir_q[DEST_POS]) begin
            w_d = w_q;
          end
        end
      end
      PH_Q4: begin
        phase_d = PH_Q1;
        end_d = 1'b1;
        pc_d = pc_q + 13'h0001;
        flush_d = 1'b0;
        ir_d = fetch_q;
        if (!flush_q) begin
          if (jump) begin
            pc_d = jump_target;
            push_d = call_op;
            flush_d = 1'b1;
          end else if (ret_op && stack_empty_n) begin
            pc_d = stack_top;
            pop_d = 1'b1;
            flush_d = 1'b1;
          end else if (skip_q) begin
            flush_d = 1'b1;
          end
          if (flush_d) begin
            ir_d = NOP_WORD;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q <= PH_Q1;
      ir_q <= NOP_WORD;
      fetch_q <= NOP_WORD;
      pc_q <= PC_RESET;
      w_q <= W_RESET;
      c_q <= 1'b0;
      z_q <= 1'b0;
      flush_q <= 1'b0;
      skip_q <= 1'b0;
      fa_q <= '0;
      rd_q <= 1'b0;
      we_q <= 1'b0;
      wd_q <= '0;
      ps_q <= 1'b0;
      push_q <= 1'b0;
      pop_q <= 1'b0;
      end_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      ir_q <= ir_d;
      fetch_q <= fetch_d;
      pc_q <= pc_d;
      w_q <= w_d;
      c_q <= c_d;
      z_q <= z_d;
      flush_q <= flush_d;
      skip_q <= skip_d;
      fa_q <= fa_d;
      rd_q <= rd_d;
      we_q <= we_d;
      wd_q <= wd_d;
      ps_q <= ps_d;
      push_q <= push_d;
      pop_q <= pop_d;
      end_q <= end_d;
    end
  end

  assign prog_addr = pc_q;
  assign file_addr = fa_q;
  assign file_rd = rd_q;
  assign file_we = we_q;
  assign file_wdata = wd_q;
  assign w_reg = w_q;
  assign carry_flag = c_q;
  assign zero_flag = z_q;
  assign prescaler_clr = ps_q;
  assign stack_push = push_q;
  assign stack_pop = pop_q;
  assign cycle_end = end_q;
  assign flush = flush_q;

  AST_CYCLE_FOUR: assert property (@(posedge clk) disable iff (rst)
    cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle not four clocks");
  AST_WRITE_NEEDS_READ: assert property (@(posedge clk) disable iff (rst)
    file_we |-> $past(file_rd))
    else $error("file write without preceding read");
  AST_JUMP_FLUSH: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && !flush_q && jump) |=> flush
    && prog_addr == $past(jump_target))
    else $error("jump did not load pc and flush");
  AST_SKIP_FLUSH: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && !flush_q && skip_q) |=> flush)
    else $error("true test did not add no-op cycle");
  AST_FLUSH_ONE: assert property (@(posedge clk) disable iff (rst)
    $rose(flush) |-> flush [*4] ##1 !flush)
    else $error("discarded cycle not exactly one");
  AST_NO_WRITE_IN_FLUSH: assert property (@(posedge clk) disable iff (rst)
    flush |-> !file_we && !file_rd)
    else $error("file access during no-op cycle");
  AST_PRESCALER: assert property (@(posedge clk) disable iff (rst)
    prescaler_clr |-> file_we && file_addr == TIMER_ZERO_COUNT_ADDR)
    else $error("prescaler clear without timer write");
  AST_DEST_W: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q3 && !flush_q && ir_q[13:12] == CAT_BYTE && !ir_q[DEST_POS]
    && ir_q[11:8] != 4'h0) |=> !file_we && w_reg == $past(res))
    else $error("d=0 result not in working register");
  AST_PC_STEP: assert property (@(posedge clk) disable iff (rst)
    (phase_q == PH_Q4 && !flush_d) |=> prog_addr == $past(pc_q) + 13'h0001)
    else $error("pc did not advance by one");
  COV_JUMP: cover property (@(posedge clk) phase_q == PH_Q4 && jump && !flush_q);
  COV_SKIP: cover property (@(posedge clk) phase_q == PH_Q4 && skip_q && !flush_q);
  COV_FWRITE: cover property (@(posedge clk) file_we);
  COV_PS: cover property (@(posedge clk) prescaler_clr);
endmodule // insn_decode

// file: tb/insn_mem_model.sv
/*
  program and file memory standing beside the decode block.
  assumes the bench loads prog and fmem before reset is released.
*/
`timescale 1ns/1ps
module insn_mem_model
  import insn_decode_pkg::*;
(
  input wire logic clk,
  input wire insn_decode_pkg::pc_t prog_addr,
  output insn_decode_pkg::word_t prog_word,
  input wire insn_decode_pkg::addr_t file_addr,
  input wire logic file_rd,
  input wire logic file_we,
  input wire insn_decode_pkg::data_t file_wdata,
  output insn_decode_pkg::data_t file_rdata
);
  import insn_decode_pkg::*;
  word_t prog [0:255];
  data_t fmem [0:127];
  data_t last_q = 8'h00;

  // words past the loaded area read as no-ops
  assign prog_word = (prog_addr < 13'h0100) ? prog[prog_addr[7:0]] : NOP_WORD;
  // pin level while read is asserted, garbage otherwise
  assign file_rdata = file_rd ? fmem[file_addr] : ~last_q;

  always @(posedge clk) begin
    if (file_rd) begin
      last_q <= fmem[file_addr];
    end
    if (file_we) begin
      fmem[file_addr] <= file_wdata;
    end
  end
endmodule // insn_mem_model

// file: tb/mcu_instruction_decode_bench.sv
/*
  self-checking bench: builds a program, notes each file write it expects.
  assumes an empty return stack; results are made visible as file writes, except W and the flags, which are checked directly at the end.
*/
`timescale 1ns/1ps
module mcu_instruction_decode_bench;
  import insn_decode_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  int errors = 0;
  int samples_checked = 0;
  int seed = 32'hc42f;
  int pc_n = 0;
  int gap = 0;
  int flushes = 0;
  logic [14:0] exp_q[$];
  data_t shadow [0:127];
  data_t w_m;
  data_t k1;
  data_t k2;
  pc_t prog_addr;
  word_t prog_word;
  addr_t file_addr;
  data_t file_rdata;
  data_t file_wdata;
  data_t w_reg;
  logic file_rd, file_we, prescaler_clr, cycle_end, flush;
  logic carry_flag, zero_flag, stack_push, stack_pop;
  logic stk_valid = 1'b0;
  pc_t stk_addr = 13'h0000;
  pc_t prev_pc = 13'h0000;
  int pushes = 0;
  int pops = 0;
  int call_ret = 0;
  logic [8:0] c_sum;
  logic rd_q = 1'b0;

  always #25 clk = ~clk;

  insn_decode i_dut (
    .clk(clk), .rst(rst), .prog_word(prog_word), .file_rdata(file_rdata),
    .stack_empty_n(stk_valid), .stack_top(stk_addr), .prog_addr(prog_addr),
    .file_addr(file_addr), .file_rd(file_rd), .file_we(file_we),
    .file_wdata(file_wdata), .w_reg(w_reg), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .prescaler_clr(prescaler_clr), .stack_push(stack_push),
    .stack_pop(stack_pop),
    .cycle_end(cycle_end), .flush(flush)
  );

  insn_mem_model i_mem (
    .clk(clk), .prog_addr(prog_addr), .prog_word(prog_word), .file_addr(file_addr),
    .file_rd(file_rd), .file_we(file_we), .file_wdata(file_wdata),
    .file_rdata(file_rdata)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic put(input word_t w);
    i_mem.prog[pc_n] = w;
    pc_n++;
  endtask

  task automatic wr(input addr_t a, input data_t d);
    shadow[a] = d;
    exp_q.push_back({a, d});
  endtask

  task automatic results();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // result watcher: each file write takes the oldest note
  always @(posedge clk) begin
    rd_q <= file_rd;
    prev_pc <= prog_addr;
    if (!rst) begin
      if (cycle_end) begin
        if (gap != 0) check("cycle_len", gap, PHASES);
        gap <= 1;
        if (flush) flushes++;
      end else if (gap != 0) begin
        gap <= gap + 1;
      end
      if (stack_push) begin
        stk_valid <= 1'b1;
        stk_addr <= prev_pc;
        pushes++;
      end
      if (stack_pop) begin
        stk_valid <= 1'b0;
        pops++;
        check("return_pc", prog_addr, call_ret);
      end
      if (file_we) begin
        check("read_before_write", rd_q, 1'b1);
        check("prescaler_clr", prescaler_clr, file_addr == TIMER_ZERO_COUNT_ADDR);
        check("write_in_flush", flush, 1'b0);
        check("write", {file_addr, file_wdata},
              exp_q.size() != 0 ? {17'h0, exp_q.pop_front()} : 32'hFFFFFFFF);
      end
    end
  end

  initial begin
    for (int i = 0; i < 128; i++) begin
      shadow[i] = $random(seed);
      i_mem.fmem[i] = shadow[i];
    end
    for (int i = 0; i < 256; i++) i_mem.prog[i] = NOP_WORD;
    k1 = $random(seed);
    k2 = $random(seed);
    put(14'h3000 | k1);
    w_m = k1;
    put(14'h00A0);
    wr(7'h20, w_m);
    put(14'h0721);
    w_m = w_m + shadow[7'h21];
    put(14'h00FF);
    wr(7'h7F, w_m);
    put(14'h07A2);
    c_sum = {1'b0, w_m} + {1'b0, shadow[7'h22]};
    wr(7'h22, w_m + shadow[7'h22]);
    put(14'h17A3);
    wr(7'h23, shadow[7'h23] | 8'h80);
    put(14'h1023);
    wr(7'h23, shadow[7'h23] & 8'hFE);
    for (int b = 0; b < 8; b++) begin
      put(14'h1428 | word_t'(b << 7));
      wr(7'h28, shadow[7'h28] | data_t'(8'h01 << b));
    end
    put(14'h0181);
    wr(7'h01, 8'h00);
    put(14'h3300 | k2);
    w_m = k2;
    put(14'h00A4);
    wr(7'h24, w_m);
    put(14'h2800 | word_t'(pc_n + 2));
    put(14'h00A5);
    put(14'h1823);
    put(14'h00A6);
    put(14'h0AA4);
    wr(7'h24, w_m + 8'h01);
    call_ret = pc_n + 1;
    put(14'h2000 | word_t'(pc_n + 3));
    put(14'h00A7);
    put(14'h2800 | word_t'(pc_n));
    put(14'h00A9);
    put(14'h0008);
    wr(7'h29, w_m);
    wr(7'h27, w_m);
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    check("pending", exp_q.size(), 0);
    check("w_reg", w_reg, k2);
    check("flush_seen", flushes != 0, 1'b1);
    check("carry_flag", carry_flag, c_sum[8]);
    check("zero_flag", zero_flag, data_t'(k2 + 8'h01) == 8'h00);
    check("pushes", pushes, 1);
    check("pops", pops, 1);
    results();
  end

  initial begin
    #(50 * 3000);
    errors++;
    results();
  end
endmodule // mcu_instruction_decode_bench
